// *** core/aie_alu.sv ***
`timescale 1ns/1ps

module aie_alu
   import aie_pkg::*;
(
   input  wire logic [7:0] a_i,
   input  wire logic [7:0] b_i,
   output logic      [7:0] sum_o,
   output aie_flag_s       flags_o
);

   logic [8:0] full_sum;
   logic [4:0] nib_sum;

   assign full_sum      = {1'b0, a_i} + {1'b0, b_i};
   assign nib_sum       = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
   assign sum_o         = full_sum[7:0];
   assign flags_o.n     = full_sum[7];
   // same-sign operands giving an opposite-sign result is a signed wrap
   assign flags_o.ov    = (a_i[7] == b_i[7]) && (full_sum[7] != a_i[7]);
   assign flags_o.z     = (full_sum[7:0] == 8'h00);
   assign flags_o.dc    = nib_sum[4];
   assign flags_o.c     = full_sum[8];

endmodule

// *** core/aie_core.sv ***
`timescale 1ns/1ps
`include "aie_map.svh"

module aie_core
   import aie_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       ce_i,
   input  wire logic [15:0] instr_i,
   input  wire logic       instr_valid_i,
   input  wire logic       ext_set_en_i,
   input  wire logic [3:0] bank_sel_i,
   input  wire logic [11:0] idx_base_i,
   input  wire logic [7:0] dmem_rdata_i,
   output aie_dmem_s       dmem_o,
   output logic      [7:0] acc_o,
   output aie_flag_s       flags_o,
   output aie_phase_e      phase_o,
   output logic            done_o
);

   aie_phase_e  phase_r;
   aie_op_e     op_r;
   logic        dest_reg_r;
   logic [7:0]  opnd_r;
   logic [7:0]  acc_r;
   aie_flag_s   flags_r;
   aie_dmem_s   dmem_r;
   logic        done_r;

   // decode of the word offered in the first phase
   logic        is_imm;
   logic        is_reg;
   logic        take;
   aie_op_e     dec_op;
   logic [7:0]  faddr;
   logic        bank_bit;
   logic        low_addr;
   logic        use_idx;
   aie_mode_e   dec_mode;
   logic [11:0] idx_addr;
   logic [11:0] dec_addr;

   assign is_imm   = (instr_i[`AIE_OPC_IMM_HI:`AIE_OPC_IMM_LO] == `AIE_OPC_IMM);
   assign is_reg   = (instr_i[`AIE_OPC_REG_HI:`AIE_OPC_REG_LO] == `AIE_OPC_REG);
   assign take     = ce_i && instr_valid_i && (phase_r == AIE_PH_Q1);
   assign dec_op   = is_imm ? AIE_OP_IMM : (is_reg ? AIE_OP_REG : AIE_OP_NONE);
   assign faddr    = instr_i[`AIE_FADDR_HI:`AIE_FADDR_LO];
   assign bank_bit = instr_i[`AIE_BIT_BANK];
   assign low_addr = (faddr <= `AIE_IDX_MAX);
   assign use_idx  = ext_set_en_i && !bank_bit && low_addr;
   assign idx_addr = idx_base_i + {4'h0, faddr};

   // indexed mode only takes over the low access-bank half, never a banked access
   assign dec_mode = bank_bit ? AIE_MODE_BANKED : (use_idx ? AIE_MODE_INDEXED : AIE_MODE_ACCESS);
   assign dec_addr = bank_bit ? {bank_sel_i, faddr} :
                     use_idx  ? idx_addr :
                     low_addr ? {`AIE_ACC_BANK_LO, faddr} :
                                {`AIE_ACC_BANK_HI, faddr};

   // processing in the third phase
   logic [7:0]  alu_sum;
   aie_flag_s   alu_flags;
   logic        active;
   logic        to_acc;

   aie_alu u_alu
   (
      .a_i     (acc_r),
      .b_i     (opnd_r),
      .sum_o   (alu_sum),
      .flags_o (alu_flags)
   );

   assign active = (op_r != AIE_OP_NONE);
   assign to_acc = (op_r == AIE_OP_IMM) || ((op_r == AIE_OP_REG) && !dest_reg_r);

   // the phase counter advances only on clocks with ce_i high, so the instruction cycle is four enabled clocks
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         phase_r    <= AIE_PH_Q1;
         op_r       <= AIE_OP_NONE;
         dest_reg_r <= 1'b0;
         opnd_r     <= `AIE_DATA_RST;
         acc_r      <= `AIE_ACC_RST;
         flags_r    <= '0;
         dmem_r     <= '{rd: 1'b0, wr: 1'b0, mode: AIE_MODE_ACCESS, addr: `AIE_ADDR_RST, wdata: `AIE_DATA_RST};
         done_r     <= 1'b0;
      end
      else if (ce_i)
      begin
         unique case (phase_r)
            AIE_PH_Q1:
            begin
               phase_r    <= AIE_PH_Q2;
               op_r       <= take ? dec_op : AIE_OP_NONE;
               dest_reg_r <= instr_i[`AIE_BIT_DEST];
               opnd_r     <= faddr;
               if (take && (dec_op == AIE_OP_REG))
               begin
                  dmem_r.rd   <= 1'b1;
                  dmem_r.mode <= dec_mode;
                  dmem_r.addr <= dec_addr;
               end
            end
            AIE_PH_Q2:
            begin
               phase_r   <= AIE_PH_Q3;
               dmem_r.rd <= 1'b0;
               if (op_r == AIE_OP_REG)
               begin
                  opnd_r <= dmem_rdata_i;
               end
            end
            AIE_PH_Q3:
            begin
               phase_r <= AIE_PH_Q4;
               done_r  <= active;
               if (active)
               begin
                  flags_r <= alu_flags;
               end
               if (to_acc)
               begin
                  acc_r <= alu_sum;
               end
               else if (active)
               begin
                  dmem_r.wr    <= 1'b1;
                  dmem_r.wdata <= alu_sum;
               end
            end
            AIE_PH_Q4:
            begin
               phase_r   <= AIE_PH_Q1;
               dmem_r.wr <= 1'b0;
               done_r    <= 1'b0;
            end
         endcase
      end
   end

   assign dmem_o  = dmem_r;
   assign acc_o   = acc_r;
   assign flags_o = flags_r;
   assign phase_o = phase_r;
   assign done_o  = done_r;

   // checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);

   logic [8:0] chk_sum;
   logic [4:0] chk_nib;
   logic       commit;

   assign chk_sum = {1'b0, acc_r} + {1'b0, opnd_r};
   assign chk_nib = {1'b0, acc_r[3:0]} + {1'b0, opnd_r[3:0]};
   assign commit  = ce_i && (phase_r == AIE_PH_Q3) && active;

   imm_add_acc_a : assert property (
      (commit && op_r == AIE_OP_IMM) |=> (acc_r == $past(chk_sum[7:0])) && !dmem_r.wr)
      else $error("immediate add did not land in accumulator");

   reg_read_a : assert property (
      (take && is_reg) |=> dmem_r.rd && (op_r == AIE_OP_REG))
      else $error("register add did not read its operand");

   dest_acc_a : assert property (
      (commit && op_r == AIE_OP_REG && !dest_reg_r) |=> (acc_r == $past(chk_sum[7:0])) && !dmem_r.wr)
      else $error("destination 0 did not write accumulator");

   dest_reg_a : assert property (
      (commit && op_r == AIE_OP_REG && dest_reg_r)
         |=> dmem_r.wr && (dmem_r.wdata == $past(chk_sum[7:0])) && $stable(acc_r))
      else $error("destination 1 did not write register");

   banked_addr_a : assert property (
      (take && is_reg && bank_bit) |=> (dmem_r.addr == {$past(bank_sel_i), $past(faddr)})
         && (dmem_r.mode == AIE_MODE_BANKED))
      else $error("banked address wrong");

   access_addr_a : assert property (
      (take && is_reg && !bank_bit && !ext_set_en_i)
         |=> (dmem_r.mode == AIE_MODE_ACCESS) && (dmem_r.addr[7:0] == $past(faddr))
         && (dmem_r.addr[11:8] == ($past(low_addr) ? `AIE_ACC_BANK_LO : `AIE_ACC_BANK_HI)))
      else $error("access bank address wrong");

   indexed_addr_a : assert property (
      (take && is_reg && use_idx) |=> (dmem_r.mode == AIE_MODE_INDEXED)
         && (dmem_r.addr == 12'($past(idx_base_i) + {4'h0, $past(faddr)})))
      else $error("indexed address wrong");

   flag_carry_a : assert property (
      commit |=> (flags_r.c == $past(chk_sum[8])) && (flags_r.dc == $past(chk_nib[4])))
      else $error("carry flags wrong");

   flag_zero_neg_a : assert property (
      commit |=> (flags_r.z == ($past(chk_sum[7:0]) == 8'h00)) && (flags_r.n == $past(chk_sum[7])))
      else $error("zero or negative flag wrong");

   flag_wrap_a : assert property (
      commit |=> flags_r.ov == (($past(acc_r[7]) == $past(opnd_r[7])) && ($past(chk_sum[7]) != $past(acc_r[7]))))
      else $error("signed wrap flag wrong");

   one_cycle_a : assert property (
      (take && (is_imm || is_reg)) ##1 ce_i [*2] |=> done_r && (phase_r == AIE_PH_Q4))
      else $error("add did not finish in one instruction cycle");

   idle_quiet_a : assert property (
      (ce_i && phase_r == AIE_PH_Q3 && !active) |=> $stable(flags_r) && $stable(acc_r) && !done_r)
      else $error("non-add word changed state");

   imm_add_c     : cover property (commit && op_r == AIE_OP_IMM);
   reg_to_acc_c  : cover property (commit && op_r == AIE_OP_REG && !dest_reg_r);
   reg_to_reg_c  : cover property (commit && op_r == AIE_OP_REG && dest_reg_r);
   indexed_c     : cover property (take && is_reg && use_idx);
   wrap_c        : cover property (commit ##1 flags_r.ov);

endmodule

// *** inc/aie_map.svh ***
`ifndef AIE_MAP_SVH
`define AIE_MAP_SVH

// opcode fields of the two add instructions
`define AIE_OPC_IMM        8'h0F
`define AIE_OPC_REG        6'h09
`define AIE_OPC_IMM_HI     15
`define AIE_OPC_IMM_LO     8
`define AIE_OPC_REG_HI     15
`define AIE_OPC_REG_LO     10

// field positions of the register-add word
`define AIE_BIT_DEST       9
`define AIE_BIT_BANK       8
`define AIE_FADDR_HI       7
`define AIE_FADDR_LO       0

// addressing limits and bank numbers
`define AIE_IDX_MAX        8'h5F
`define AIE_ACC_BANK_LO    4'h0
`define AIE_ACC_BANK_HI    4'hF

// reset values
`define AIE_ACC_RST        8'h00
`define AIE_DATA_RST       8'h00
`define AIE_ADDR_RST       12'h000

`endif

// *** inc/aie_pkg.sv ***
package aie_pkg;

   typedef enum logic [1:0]
   {
      AIE_PH_Q1 = 2'b00,
      AIE_PH_Q2 = 2'b01,
      AIE_PH_Q3 = 2'b10,
      AIE_PH_Q4 = 2'b11
   } aie_phase_e;

   typedef enum logic [1:0]
   {
      AIE_OP_NONE = 2'b00,
      AIE_OP_IMM  = 2'b01,
      AIE_OP_REG  = 2'b10
   } aie_op_e;

   typedef enum logic [1:0]
   {
      AIE_MODE_ACCESS  = 2'b00,
      AIE_MODE_BANKED  = 2'b01,
      AIE_MODE_INDEXED = 2'b10
   } aie_mode_e;

   typedef struct packed
   {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } aie_flag_s;

   typedef struct packed
   {
      logic       rd;
      logic       wr;
      aie_mode_e  mode;
      logic [11:0] addr;
      logic [7:0] wdata;
   } aie_dmem_s;

endpackage

// *** tb/aie_core_tb_top.sv ***
`timescale 1ns/1ps
`define AIE_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module aie_core_tb_top
   import aie_pkg::*;
();
   logic        core_clk_i;
   logic        rstn_i;
   logic        ce_i;
   logic [15:0] instr_i;
   logic        instr_valid_i;
   logic        ext_set_en_i;
   logic [3:0]  bank_sel_i;
   logic [11:0] idx_base_i;
   logic [7:0]  dmem_rdata_i;
   aie_dmem_s   dmem_o;
   logic [7:0]  acc_o;
   aie_flag_s   flags_o;
   aie_phase_e  phase_o;
   logic        done_o;
   logic [7:0]  acc_m;
   aie_flag_s   flags_m;
   int          n_mismatch;
   int          comparisons;

   aie_core aie_core_inst (
      .core_clk_i    (core_clk_i),
      .rstn_i        (rstn_i),
      .ce_i          (ce_i),
      .instr_i       (instr_i),
      .instr_valid_i (instr_valid_i),
      .ext_set_en_i  (ext_set_en_i),
      .bank_sel_i    (bank_sel_i),
      .idx_base_i    (idx_base_i),
      .dmem_rdata_i  (dmem_rdata_i),
      .dmem_o        (dmem_o),
      .acc_o         (acc_o),
      .flags_o       (flags_o),
      .phase_o       (phase_o),
      .done_o        (done_o)
   );

   always #5 core_clk_i = ~core_clk_i;

   // own flag model, kept apart from the design's adder on purpose
   function automatic aie_flag_s fl(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      aie_flag_s  f;
      s = {1'b0, a} + {1'b0, b};
      f.n = s[7];
      f.ov = (a[7] == b[7]) && (s[7] != a[7]);
      f.z = (s[7:0] == 8'h00);
      f.dc = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
      f.c = s[8];
      return f;
   endfunction

   // offers one word at a Q1 edge; stall drops ce_i for that many cycles inside Q2
   task automatic run(input logic [15:0] w, input logic [7:0] m, input logic ext, input logic [3:0] bs,
                      input logic [11:0] base, input logic [11:0] ea, input aie_mode_e em, input int stall);
      logic      isreg;
      logic      isadd;
      logic      d;
      logic [7:0] opnd;
      logic [7:0] s;
      int        k;
      isreg = (w[15:10] == 6'h09);
      isadd = isreg || (w[15:8] == 8'h0F);
      d = isreg && w[9];
      opnd = isreg ? m : w[7:0];
      s = acc_m + opnd;
      k = 0;
      // phase is read settled on the falling edge; the word goes out at the Q4 edge
      while (phase_o !== AIE_PH_Q4 && k < 8)
      begin
         @(negedge core_clk_i);
         k++;
      end
      `AIE_CHK(phase_o, AIE_PH_Q4)
      @(posedge core_clk_i);
      instr_i <= w;
      instr_valid_i <= 1'b1;
      dmem_rdata_i <= m;
      ext_set_en_i <= ext;
      bank_sel_i <= bs;
      idx_base_i <= base;
      @(posedge core_clk_i);
      instr_valid_i <= 1'b0;
      if (stall > 0)
         ce_i <= 1'b0;
      repeat (stall)
      begin
         @(negedge core_clk_i);
         `AIE_CHK(phase_o, AIE_PH_Q2)
         @(posedge core_clk_i);
      end
      // enable comes back only after the whole stall, so every stalled edge stays frozen
      ce_i <= 1'b1;
      @(negedge core_clk_i);
      `AIE_CHK(dmem_o.rd, isreg)
      if (isreg)
      begin
         `AIE_CHK(dmem_o.addr, ea)
         `AIE_CHK(dmem_o.mode, em)
      end
      repeat (2) @(negedge core_clk_i);
      if (isadd)
      begin
         flags_m = fl(acc_m, opnd);
         if (!d)
            acc_m = s;
      end
      `AIE_CHK(done_o, isadd)
      `AIE_CHK(flags_o, flags_m)
      `AIE_CHK(acc_o, acc_m)
      `AIE_CHK(dmem_o.wr, d)
      if (d)
         `AIE_CHK(dmem_o.wdata, s)
   endtask

   task automatic t_reset();
      @(negedge core_clk_i);
      `AIE_CHK(phase_o, AIE_PH_Q1)
      `AIE_CHK(acc_o, 8'h00)
      `AIE_CHK(flags_o, 5'h00)
      `AIE_CHK(dmem_o, 24'h000000)
      `AIE_CHK(done_o, 1'b0)
   endtask

   // back to back: two plain sums, nibble carry with signed wrap and negative, carry with zero, plain negative
   task automatic t_imm();
      run(16'h0F10, 8'hA5, 1'b0, 4'h0, 12'h000, 12'h000, AIE_MODE_ACCESS, 0);
      run(16'h0F15, 8'hA5, 1'b0, 4'h0, 12'h000, 12'h000, AIE_MODE_ACCESS, 0);
      run(16'h0F6B, 8'hA5, 1'b0, 4'h0, 12'h000, 12'h000, AIE_MODE_ACCESS, 0);
      run(16'h0F70, 8'hA5, 1'b0, 4'h0, 12'h000, 12'h000, AIE_MODE_ACCESS, 2);
      run(16'h0F88, 8'hA5, 1'b1, 4'h0, 12'h000, 12'h000, AIE_MODE_ACCESS, 0);
   endtask

   // every addressing mode, both destinations, 5Fh taken as indexed and 60h going to the upper access bank
   task automatic t_reg();
      run(16'h24C2, 8'hC2, 1'b0, 4'h3, 12'h123, 12'hFC2, AIE_MODE_ACCESS, 0);
      run(16'h2733, 8'h7F, 1'b1, 4'h5, 12'h123, 12'h533, AIE_MODE_BANKED, 0);
      run(16'h245F, 8'h01, 1'b1, 4'h5, 12'h123, 12'h182, AIE_MODE_INDEXED, 3);
      run(16'h2660, 8'h80, 1'b1, 4'h5, 12'h123, 12'hF60, AIE_MODE_ACCESS, 0);
      run(16'h2410, 8'hFF, 1'b0, 4'hA, 12'h123, 12'h010, AIE_MODE_ACCESS, 0);
   endtask

   // neighbouring opcodes must do nothing at all
   task automatic t_ignore();
      run(16'h0B05, 8'h11, 1'b0, 4'h0, 12'h000, 12'h000, AIE_MODE_ACCESS, 0);
      run(16'h2005, 8'h11, 1'b0, 4'h0, 12'h000, 12'h000, AIE_MODE_ACCESS, 0);
   endtask

   task automatic summarize();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      core_clk_i = 1'b0;
      rstn_i = 1'b0;
      ce_i = 1'b1;
      instr_i = 16'h0000;
      instr_valid_i = 1'b0;
      ext_set_en_i = 1'b0;
      bank_sel_i = 4'h0;
      idx_base_i = 12'h000;
      dmem_rdata_i = 8'h00;
      acc_m = 8'h00;
      flags_m = 5'h00;
      n_mismatch = 0;
      comparisons = 0;
      repeat (10) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_imm();
      t_reg();
      t_ignore();
      summarize();
   end

   // whole run needs well under 1000 cycles
   initial
   begin
      #100000;
      n_mismatch++;
      summarize();
   end
endmodule
